// file: hdl/crfs_params.svh
// Constants for the core rail fault supervisor.
// Assumes inclusion by bare name; definitions only.
`ifndef CRFS_PARAMS_SVH
`define CRFS_PARAMS_SVH
// APB register byte addresses
`define CRFS_ADDR_CTRL 12'h000
`define CRFS_ADDR_STATUS 12'h004
`define CRFS_ADDR_CURRENT_MONITOR_NODE 12'h008
`define CRFS_ADDR_CONFIG 12'h00c
`define CRFS_ADDR_TIMING 12'h010
// Control register fields
`define CRFS_CTRL_EN_BIT 0
`define CRFS_CTRL_DYNAMIC_VOLTAGE_STEP_UP_BIT 1
`define CRFS_CTRL_DYNAMIC_VOLTAGE_STEP_DN_BIT 2
`define CRFS_CTRL_DEM_BIT 3
// Timing register fields
`define CRFS_TIM_TRIG_LSB 0
`define CRFS_TIM_ACT_LSB 16
`define CRFS_TIM_FIELD_W 16
`define CRFS_TIM_TRIG_RST 16'h00c8
`define CRFS_TIM_ACT_RST 16'h00c8
// Times as printed, in ns
`define CRFS_OVP_DELAY_NS 1000
`define CRFS_UVP_DELAY_NS 3000
`define CRFS_SUPPLY_LOCKOUT_DELAY_NS 3000
`define CRFS_CLK_NS 5
// Telemetry: 512 codes (0 to 511) at 6.25 mV, in microvolts
`define CRFS_CURRENT_MONITOR_NODE_MAX 9'h1ff
`define CRFS_CURRENT_MONITOR_NODE_LSB_UV 6250
`define CRFS_CURRENT_MONITOR_NODE_FS_UV 3193750
// Voltage thresholds in mV, then the counter width in bits
`define CRFS_OVP_FLOOR_MV 900
`define CRFS_OVP_MARGIN_MV 325
`define CRFS_UVP_MARGIN_MV 500
`define CRFS_OFS_SENSE_MV 300
`define CRFS_CNT_W 16
`endif

// file: hdl/crfs_pkg.sv
// Types of the core rail fault supervisor.
// Assumes crfs_params.svh for widths.
`include "crfs_params.svh"
package crfs_pkg;
	typedef enum logic [3:0] {
		CRFS_OC_IDLE = 4'b0001,
		CRFS_OC_WAIT = 4'b0010,
		CRFS_OC_TRIP = 4'b0100,
		CRFS_OC_RSVD = 4'b1000
	} crfs_oc_t;

	typedef struct packed {
		logic en;
		logic dynamic_voltage_step_up;
		logic dynamic_voltage_step_dn;
		logic dem_req;
		logic en_d;
		logic init_ofs_dis;
		logic ccm_forced;
		logic [15:0] trig_dly;
		logic [15:0] act_dly;
		logic [15:0] tdc_cnt;
		logic [15:0] act_cnt;
		logic [15:0] ov_cnt;
		logic [15:0] uv_cnt;
		logic [15:0] lo_cnt;
		crfs_oc_t oc_state;
		logic overvoltage_latch;
		logic undervoltage_latch;
		logic negative_voltage_guard;
		logic lockout;
		logic oc_trip;
		logic oc_ind_n;
		logic [8:0] current_monitor_node_code;
		logic qr_active;
		logic [15:0] qr_cnt;
		logic hs_en;
		logic ls_en;
		logic nb_shutdown;
		logic [31:0] prdata;
	} crfs_state_t;
endpackage : crfs_pkg

// file: hdl/crfs_top.sv
// Core rail fault supervisor: offset, dynamic step, telemetry and protection.
// Assumes comparator and strap inputs synchronous to pclk; APB register access.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "crfs_params.svh"

module crfs_top #(
	parameter int SENSE_W = 12,
	parameter logic [15:0] TON_CYCLES = 16'h0040
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Straps and sense (millivolt codes)
	input wire logic config_strap_one,
	input wire logic config_strap_two,
	input wire logic core_offset_sense_input,
	input wire logic [SENSE_W-1:0] core_offset_sense_mv,
	input wire logic [SENSE_W-1:0] core_voltage_sense,
	input wire logic core_voltage_negative,
	input wire logic [SENSE_W-1:0] target_mv,
	input wire logic [SENSE_W-1:0] current_monitor_node,
	input wire logic supply_below_por,
	// Comparators from the loop
	input wire logic oc_above_tdc,
	input wire logic oc_above_spike,
	input wire logic switch_cycle,
	input wire logic qr_detect,
	input wire logic ton_pulse,
	// Gate and rail outputs
	output logic hs_gate_en,
	output logic ls_gate_en,
	output logic ton_out,
	output logic overcurrent_indicator_n,
	output logic second_rail_shutdown,
	output logic continuous_conduction_mode,
	output logic init_offset_disable,
	output logic core_ext_offset_en,
	output logic aux_rail_ext_shift_enable,
	output logic [1:0] dynamic_voltage_step_comp_bits,
	output logic ramp_amp_sel
);
	localparam logic [15:0] OV_CYC = 16'((`CRFS_OVP_DELAY_NS + `CRFS_CLK_NS - 1) / `CRFS_CLK_NS);
	localparam logic [15:0] UV_CYC = 16'((`CRFS_UVP_DELAY_NS + `CRFS_CLK_NS - 1) / `CRFS_CLK_NS);
	localparam logic [15:0] LO_CYC = 16'((`CRFS_SUPPLY_LOCKOUT_DELAY_NS + `CRFS_CLK_NS - 1) / `CRFS_CLK_NS);

	crfs_pkg::crfs_state_t r;
	crfs_pkg::crfs_state_t next_r;

	// Saturating persistence counter shared by the four filtered faults
	function automatic logic [15:0] persist(input logic cond, input logic [15:0] cnt,
			input logic [15:0] lim);
		if (!cond)
			persist = 16'h0000;
		else if (cnt < lim)
			persist = cnt + 16'h0001;
		else
			persist = cnt;
	endfunction : persist

	logic wr_en;
	logic rd_en;
	logic [31:0] rd_mux;
	logic [SENSE_W:0] ovp_limit;
	logic ov_cond;
	logic uv_cond;
	logic [31:0] current_monitor_node_uv;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_comb begin
		// Fixed floor below 0.9 V target, tracking reference above it
		if (target_mv < SENSE_W'(`CRFS_OVP_FLOOR_MV))
			ovp_limit = (SENSE_W+1)'(`CRFS_OVP_FLOOR_MV + `CRFS_OVP_MARGIN_MV);
		else
			ovp_limit = {1'b0, target_mv} + (SENSE_W+1)'(`CRFS_OVP_MARGIN_MV);
		ov_cond = {1'b0, core_voltage_sense} > ovp_limit;
		uv_cond = ({1'b0, core_voltage_sense} + (SENSE_W+1)'(`CRFS_UVP_MARGIN_MV))
			<= {1'b0, target_mv};
		current_monitor_node_uv = 32'(current_monitor_node) * 32'd1000;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`CRFS_ADDR_CTRL: rd_mux = {28'h0, r.dem_req, r.dynamic_voltage_step_dn, r.dynamic_voltage_step_up, r.en};
			`CRFS_ADDR_STATUS: rd_mux = {22'h0, r.ccm_forced, r.init_ofs_dis, r.nb_shutdown,
				r.lockout, r.negative_voltage_guard, r.undervoltage_latch, r.overvoltage_latch, r.oc_trip, ~r.oc_ind_n, r.qr_active};
			`CRFS_ADDR_CURRENT_MONITOR_NODE: rd_mux = {23'h0, r.current_monitor_node_code};
			`CRFS_ADDR_CONFIG: rd_mux = {27'h0, config_strap_one, config_strap_two,
				config_strap_two, config_strap_one, config_strap_one};
			`CRFS_ADDR_TIMING: rd_mux = {r.act_dly, r.trig_dly};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_r = r;
		if (rd_en)
			next_r.prdata = rd_mux;
		if (wr_en && paddr == `CRFS_ADDR_CTRL) begin
			next_r.en = pwdata[`CRFS_CTRL_EN_BIT];
			next_r.dynamic_voltage_step_up = pwdata[`CRFS_CTRL_DYNAMIC_VOLTAGE_STEP_UP_BIT];
			next_r.dynamic_voltage_step_dn = pwdata[`CRFS_CTRL_DYNAMIC_VOLTAGE_STEP_DN_BIT];
			next_r.dem_req = pwdata[`CRFS_CTRL_DEM_BIT];
		end
		if (wr_en && paddr == `CRFS_ADDR_TIMING) begin
			next_r.trig_dly = pwdata[`CRFS_TIM_TRIG_LSB +: `CRFS_TIM_FIELD_W];
			next_r.act_dly = pwdata[`CRFS_TIM_ACT_LSB +: `CRFS_TIM_FIELD_W];
		end
		next_r.en_d = r.en;
		// Enable rising edge: sample the offset-sense threshold once
		if (r.en && !r.en_d)
			next_r.init_ofs_dis = core_offset_sense_mv < SENSE_W'(`CRFS_OFS_SENSE_MV);
		// Up-step forces CONTINUOUS_CONDUCTION_MODE; down-step leaves the mode alone
		if (r.dynamic_voltage_step_up)
			next_r.ccm_forced = 1'b1;
		else if (!r.dynamic_voltage_step_dn)
			next_r.ccm_forced = 1'b0;

		// Telemetry: divide microvolts by LSB, clamp to top code
		if (current_monitor_node_uv >= 32'(`CRFS_CURRENT_MONITOR_NODE_FS_UV))
			next_r.current_monitor_node_code = `CRFS_CURRENT_MONITOR_NODE_MAX;
		else
			next_r.current_monitor_node_code = 9'(current_monitor_node_uv / 32'(`CRFS_CURRENT_MONITOR_NODE_LSB_UV));

		// Quick response pulse about one nominal on-time long
		if (qr_detect && !r.qr_active) begin
			next_r.qr_active = 1'b1;
			next_r.qr_cnt = TON_CYCLES;
		end else if (r.qr_active) begin
			if (r.qr_cnt <= 16'h0001)
				next_r.qr_active = 1'b0;
			next_r.qr_cnt = r.qr_cnt - 16'h0001;
		end

		next_r.tdc_cnt = persist(oc_above_tdc, r.tdc_cnt, r.trig_dly);
		next_r.oc_trip = 1'b0;
		if ((oc_above_tdc && r.tdc_cnt >= r.trig_dly)
				|| (switch_cycle && oc_above_spike))
			next_r.oc_trip = 1'b1;
		unique case (r.oc_state)
			crfs_pkg::CRFS_OC_IDLE: begin
				if (next_r.oc_trip) begin
					next_r.oc_ind_n = 1'b0;
					next_r.act_cnt = 16'h0000;
					next_r.oc_state = crfs_pkg::CRFS_OC_WAIT;
				end
			end
			crfs_pkg::CRFS_OC_WAIT: begin
				next_r.act_cnt = r.act_cnt + 16'h0001;
				if (r.act_cnt >= r.act_dly) begin
					if (oc_above_tdc || oc_above_spike) begin
						next_r.oc_state = crfs_pkg::CRFS_OC_TRIP;
					end else begin
						next_r.oc_ind_n = 1'b1;
						next_r.oc_state = crfs_pkg::CRFS_OC_IDLE;
					end
				end
			end
			crfs_pkg::CRFS_OC_TRIP: begin
				// Gates stay off until enable is dropped, except the low side while over-voltage is latched
				if (!r.en) begin
					next_r.oc_ind_n = 1'b1;
					next_r.oc_state = crfs_pkg::CRFS_OC_IDLE;
				end
			end
			default: next_r.oc_state = crfs_pkg::CRFS_OC_IDLE;
		endcase

		// Monitoring runs only out of reset, since r holds reset values until then
		next_r.ov_cnt = persist(ov_cond, r.ov_cnt, OV_CYC);
		if (ov_cond && r.ov_cnt >= OV_CYC - 16'h0001)
			next_r.overvoltage_latch = 1'b1;
		next_r.uv_cnt = persist(uv_cond, r.uv_cnt, UV_CYC);
		if (uv_cond && r.uv_cnt >= UV_CYC - 16'h0001 && r.en)
			next_r.undervoltage_latch = 1'b1;
		next_r.negative_voltage_guard = r.overvoltage_latch && core_voltage_negative;
		next_r.lo_cnt = persist(supply_below_por, r.lo_cnt, LO_CYC);
		next_r.lockout = supply_below_por && r.lo_cnt >= LO_CYC - 16'h0001;
		// Enable falling edge clears the protection latches; over-voltage set wins in the same cycle
		if (!r.en && !next_r.overvoltage_latch)
			next_r.overvoltage_latch = 1'b0;
		if (!r.en && r.en_d) begin
			next_r.overvoltage_latch = next_r.overvoltage_latch && ov_cond && r.ov_cnt >= OV_CYC - 16'h0001;
			next_r.undervoltage_latch = 1'b0;
		end
		next_r.nb_shutdown = next_r.overvoltage_latch || next_r.undervoltage_latch;

		// Gate priority: lockout, over-voltage, under-voltage, over-current
		if (r.lockout || !r.en) begin
			next_r.hs_en = 1'b0;
			next_r.ls_en = 1'b0;
		end else if (r.overvoltage_latch) begin
			next_r.hs_en = 1'b0;
			next_r.ls_en = !r.negative_voltage_guard;
		end else if (r.undervoltage_latch || r.oc_state == crfs_pkg::CRFS_OC_TRIP) begin
			next_r.hs_en = 1'b0;
			next_r.ls_en = 1'b0;
		end else begin
			next_r.hs_en = 1'b1;
			next_r.ls_en = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.trig_dly <= `CRFS_TIM_TRIG_RST;
			r.act_dly <= `CRFS_TIM_ACT_RST;
			r.oc_state <= crfs_pkg::CRFS_OC_IDLE;
			r.oc_ind_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign hs_gate_en = r.hs_en;
	assign ls_gate_en = r.ls_en;
	assign ton_out = r.qr_active | (ton_pulse & ~r.qr_active);
	assign overcurrent_indicator_n = r.oc_ind_n;
	assign second_rail_shutdown = r.nb_shutdown;
	assign continuous_conduction_mode = r.ccm_forced | ~r.dem_req;
	assign init_offset_disable = r.init_ofs_dis;
	assign core_ext_offset_en = config_strap_two & core_offset_sense_input;
	assign aux_rail_ext_shift_enable = config_strap_two;
	assign dynamic_voltage_step_comp_bits = {config_strap_two, config_strap_one};
	assign ramp_amp_sel = config_strap_one;
endmodule : crfs_top

// file: tb/crfs_far_side.sv
// Far-side model: power stage and second rail controller.
// Assumes gate enables and shutdown request registered on pclk.
`timescale 1ns/1ps
module crfs_far_side (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Stage controls
	input wire logic hs_gate_en,
	input wire logic ls_gate_en,
	input wire logic second_rail_shutdown,
	// Observed state
	output logic shoot_through,
	output logic aux_soft_off
);
	// Soft shutdown of the second rail is one-way until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shoot_through <= 1'b0;
			aux_soft_off <= 1'b0;
		end else begin
			shoot_through <= hs_gate_en & ls_gate_en;
			aux_soft_off <= aux_soft_off | second_rail_shutdown;
		end
	end
endmodule : crfs_far_side

// file: tb/crfs_top_properties.sv
// Checker for the core rail fault supervisor ports.
// Assumes binding into crfs_top; single pclk domain.
`timescale 1ns/1ps
module crfs_top_properties (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Watched inputs
	input wire logic config_strap_one,
	input wire logic config_strap_two,
	input wire logic supply_below_por,
	input wire logic oc_above_tdc,
	input wire logic oc_above_spike,
	input wire logic switch_cycle,
	input wire logic qr_detect,
	// Watched outputs
	input wire logic hs_gate_en,
	input wire logic ls_gate_en,
	input wire logic ton_out,
	input wire logic overcurrent_indicator_n,
	input wire logic second_rail_shutdown,
	input wire logic aux_rail_ext_shift_enable,
	input wire logic [1:0] dynamic_voltage_step_comp_bits,
	input wire logic ramp_amp_sel
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic oc_any;
	logic [9:0] low_cnt;
	assign oc_any = oc_above_tdc | oc_above_spike;
	// Saturates so a long brown-out cannot wrap back to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) low_cnt <= 10'h000;
		else if (!supply_below_por) low_cnt <= 10'h000;
		else if (low_cnt != 10'h3ff) low_cnt <= low_cnt + 10'h001;
	end
	a_lockout_gates_off: assert property (low_cnt > 10'h25a |-> !hs_gate_en && !ls_gate_en)
		else $error("gates on during lockout");
	a_oc_ind_cause: assert property ($fell(overcurrent_indicator_n) |-> $past(oc_any) || $past(oc_any, 2))
		else $error("indicator fell without over-current");
	a_spike_sets_ind: assert property (oc_above_spike && switch_cycle |-> ##[1:3] !overcurrent_indicator_n)
		else $error("spike did not assert indicator");
	a_qr_pulse_out: assert property ($rose(qr_detect) |-> ##[0:2] ton_out)
		else $error("no quick response pulse");
	a_ramp_follows: assert property ($changed(config_strap_one) |-> $changed(ramp_amp_sel))
		else $error("ramp select ignored strap one");
	a_comp_cause: assert property ($changed(dynamic_voltage_step_comp_bits) |-> $changed(config_strap_one) || $changed(config_strap_two))
		else $error("compensation bits moved without strap change");
	a_offset_cause: assert property ($changed(aux_rail_ext_shift_enable) |-> $changed(config_strap_one) || $changed(config_strap_two))
		else $error("offset enable moved without strap change");
	a_shutdown_hs_off: assert property ($rose(second_rail_shutdown) |-> ##[0:2] !hs_gate_en)
		else $error("high side on with shutdown request");
endmodule : crfs_top_properties
bind crfs_top crfs_top_properties u_props (.pclk, .presetn, .config_strap_one, .config_strap_two,
	.supply_below_por, .oc_above_tdc, .oc_above_spike, .switch_cycle, .qr_detect, .hs_gate_en,
	.ls_gate_en, .ton_out, .overcurrent_indicator_n, .second_rail_shutdown,
	.aux_rail_ext_shift_enable, .dynamic_voltage_step_comp_bits, .ramp_amp_sel);

// file: tb/tb_top.sv
// Testbench for the core rail fault supervisor.
// Assumes zero-wait APB slave; quick response shortened to 8 cycles.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic [11:0] mv; logic [8:0] code;} crfs_row_t;
	crfs_row_t rows [5] = '{'{12'h000, 9'h000}, '{12'h006, 9'h000}, '{12'h007, 9'h001},
		'{12'hc79, 9'h1fe}, '{12'hfa0, 9'h1ff}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, core_voltage_sense, target_mv, current_monitor_node;
	logic [31:0] pwdata, prdata, q;
	logic config_strap_one, config_strap_two, core_voltage_negative, supply_below_por;
	logic oc_above_spike, switch_cycle, qr_detect, hs_gate_en, ls_gate_en, ton_out;
	logic overcurrent_indicator_n, second_rail_shutdown, continuous_conduction_mode;
	logic core_ext_offset_en, aux_rail_ext_shift_enable, ramp_amp_sel, shoot_through, aux_soft_off;
	logic core_offset_sense_input;
	logic [1:0] dynamic_voltage_step_comp_bits;
	int num_errors = 0;
	int total_checks = 0;
	crfs_top #(.SENSE_W(12), .TON_CYCLES(16'h0008)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .config_strap_one,
		.config_strap_two, .core_offset_sense_input, .core_offset_sense_mv(12'h000),
		.core_voltage_sense, .core_voltage_negative, .target_mv, .current_monitor_node,
		.supply_below_por, .oc_above_tdc(1'b0), .oc_above_spike, .switch_cycle, .qr_detect,
		.ton_pulse(1'b0), .hs_gate_en, .ls_gate_en, .ton_out, .overcurrent_indicator_n,
		.second_rail_shutdown, .continuous_conduction_mode, .init_offset_disable(),
		.core_ext_offset_en, .aux_rail_ext_shift_enable, .dynamic_voltage_step_comp_bits, .ramp_amp_sel);
	crfs_far_side far (.pclk, .presetn, .hs_gate_en, .ls_gate_en, .second_rail_shutdown,
		.shoot_through, .aux_soft_off);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#100000;
		num_errors++;
		finish_test();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{config_strap_one, config_strap_two, core_voltage_negative, supply_below_por} = '0;
		{oc_above_spike, switch_cycle, qr_detect, current_monitor_node} = '0;
		target_mv = 12'h3e8;
		core_offset_sense_input = 1'b1;
		core_voltage_sense = 12'h3e8;
		cyc(10);
		presetn <= 1'b1;
		chk(32'(overcurrent_indicator_n), 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk(q, 32'h00c800c8);
		foreach (rows[i]) begin
			current_monitor_node <= rows[i].mv;
			cyc(3);
			apb(1'b0, 12'h008, 32'h0);
			chk(q, {23'h0, rows[i].code});
		end
		$display("telemetry rows done");
		config_strap_one <= 1'b1;
		config_strap_two <= 1'b1;
		cyc(2);
		chk(32'({core_ext_offset_en, aux_rail_ext_shift_enable}), 32'h3);
		chk(32'(dynamic_voltage_step_comp_bits), 32'h3);
		config_strap_one <= 1'b0;
		config_strap_two <= 1'b0;
		cyc(2);
		chk(32'({core_ext_offset_en, aux_rail_ext_shift_enable}), 32'h0);
		apb(1'b1, 12'h000, 32'h9);
		cyc(2);
		chk(32'(continuous_conduction_mode), 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(32'(q[8]), 32'h1);
		apb(1'b1, 12'h000, 32'hd);
		cyc(2);
		chk(32'(continuous_conduction_mode), 32'h0);
		apb(1'b1, 12'h000, 32'hb);
		cyc(2);
		chk(32'(continuous_conduction_mode), 32'h1);
		apb(1'b1, 12'h000, 32'h1);
		qr_detect <= 1'b1;
		cyc(1);
		qr_detect <= 1'b0;
		cyc(2);
		chk(32'(ton_out), 32'h1);
		cyc(12);
		chk(32'(ton_out), 32'h0);
		$display("modes and quick response done");
		apb(1'b1, 12'h010, 32'h000a000a);
		{oc_above_spike, switch_cycle} <= 2'b11;
		cyc(4);
		chk(32'(overcurrent_indicator_n), 32'h0);
		cyc(20);
		chk(32'({hs_gate_en, ls_gate_en}), 32'h0);
		{oc_above_spike, switch_cycle} <= 2'b00;
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
		$display("over-current done");
		// Sits between the floor limit and reference plus margin
		target_mv <= 12'h320;
		core_voltage_sense <= 12'h4b0;
		cyc(250);
		chk(32'(second_rail_shutdown), 32'h0);
		core_voltage_sense <= 12'h4ce;
		cyc(190);
		chk(32'(second_rail_shutdown), 32'h0);
		cyc(20);
		chk(32'(second_rail_shutdown), 32'h1);
		chk(32'({hs_gate_en, ls_gate_en}), 32'h1);
		core_voltage_negative <= 1'b1;
		cyc(3);
		chk(32'({hs_gate_en, ls_gate_en}), 32'h0);
		core_voltage_negative <= 1'b0;
		cyc(3);
		chk(32'({hs_gate_en, ls_gate_en}), 32'h1);
		core_voltage_sense <= 12'h320;
		apb(1'b1, 12'h000, 32'h0);
		cyc(3);
		chk(32'(second_rail_shutdown), 32'h0);
		$display("over-voltage done");
		target_mv <= 12'h3e8;
		core_voltage_sense <= 12'h1f4;
		apb(1'b1, 12'h000, 32'h1);
		cyc(590);
		chk(32'(second_rail_shutdown), 32'h0);
		cyc(20);
		chk(32'({second_rail_shutdown, hs_gate_en, ls_gate_en}), 32'h4);
		core_voltage_sense <= 12'h3e8;
		cyc(5);
		chk(32'({second_rail_shutdown, aux_soft_off}), 32'h3);
		apb(1'b1, 12'h000, 32'h1);
		$display("under-voltage done");
		supply_below_por <= 1'b1;
		cyc(700);
		chk(32'({hs_gate_en, ls_gate_en, shoot_through}), 32'h0);
		supply_below_por <= 1'b0;
		$display("lockout done");
		finish_test();
	end
endmodule : tb_top
